/* File: hw/shc_consts.vh */
`ifndef SHC_CONSTS_VH
`define SHC_CONSTS_VH

// ----------------------------------------
// Register indexes (byte address = 4 * index)
// ----------------------------------------
`define SHC_SETTLE_SEL_IDX 16'hfffa
`define SHC_STAT_IDX 16'hfffb

// ----------------------------------------
// Settle select field
// ----------------------------------------
`define SHC_SEL_W 3
`define SHC_SETTLE_SEL_RST 3'h4
`define SHC_SEL_2P12 3'h0
`define SHC_SEL_2P15 3'h2
`define SHC_SEL_2P17 3'h4

// ----------------------------------------
// Timing counts in fx cycles
// ----------------------------------------
`define SHC_CNT_2P12 4096
`define SHC_CNT_2P15 32768
`define SHC_CNT_2P17 131072
`define SHC_CNT_RESET 32768
`define SHC_RESUME_NEXT 1
`define SHC_RESUME_VEC 9
`define SHC_CNT_W 18

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define SHC_STAT_STATE_LSB 0
`define SHC_STAT_RESET_BIT 3
`define SHC_STAT_OSCOFF_BIT 4
`define SHC_STAT_OSCRDY_BIT 5

`endif

/* File: hw/shc_standby_ctrl.v */
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "shc_consts.vh"

// Notes on behaviour
// - Halt gates CPU clock, oscillator keeps running
// - Stop switches the main oscillator off
// - Standby leaves all held state untouched
// - Select code picks 2^12, 2^15, 2^17 wait
// - Reset loads code 4, waits 2^15
// - Settle count starts once oscillator runs
// - Unmasked request ends halt, vector or next
// - Halt resume: 9 vectored, 1 otherwise
// - Non-maskable request ends halt, always vectored
// - Reset out of halt runs reset vector
// - Masked requests never wake from standby
// - Halt keeps timers, watchdog, serial running
// - Stop stops timers; serial only external clock
// - Power-on-clear active only when mask clear
// - Pending request at stop: halt then settle
// - Request ends stop; settle then vector/next
// - Reset out of stop waits settle first
// - Stop ends only by maskable request, reset
// - Eligible: request 1, mask 0; vector needs enable

module shc_standby_ctrl #(
  parameter NUM_IRQ = 8,
  parameter CNT_2P15 = `SHC_CNT_2P15,
  parameter CNT_2P17 = `SHC_CNT_2P17,
  parameter CNT_RESET = `SHC_CNT_RESET
) (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // CPU core and interrupt controller
  input wire haltExec,
  input wire stopExec,
  input wire [NUM_IRQ-1:0] irqRequestFlag,
  input wire [NUM_IRQ-1:0] irqMaskFlag,
  input wire irqGlobalAllow,
  input wire nmiReq,
  input wire powerClearIrqMask,
  input wire serialExtClkSel,
  // Oscillator
  input wire oscRunning,
  output reg oscEnable_q,
  // CPU clock and resume
  output reg cpuClkEn_q,
  output reg resumeVector_q,
  output reg resumeNext_q,
  output reg resetStart_q,
  // Peripheral clock gates
  output reg timerClkEn_q,
  output reg wdtClkEn_q,
  output reg serialClkEn_q,
  output reg lowVoltDetEn_q,
  output reg wakeDetEnable_q,
  output reg powerClearEn_q
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_RUN = 3'h0;
  localparam ST_HALT = 3'h1;
  localparam ST_STOP = 3'h2;
  localparam ST_OSCUP = 3'h3;
  localparam ST_SETTLE = 3'h4;
  localparam ST_RESUME = 3'h5;

  localparam [`SHC_CNT_W-1:0] CNT_ONE = 18'h00001;

  // ----------------------------------------
  // Count constants, cut to counter width
  // ----------------------------------------
  localparam integer CNT_2P12 = `SHC_CNT_2P12;
  localparam integer RESUME_VEC_LAST = `SHC_RESUME_VEC - 1;
  localparam integer RESUME_NEXT_LAST = `SHC_RESUME_NEXT - 1;
  localparam [`SHC_CNT_W-1:0] CNT_2P12_W = CNT_2P12[`SHC_CNT_W-1:0];
  localparam [`SHC_CNT_W-1:0] VEC_LAST = RESUME_VEC_LAST[`SHC_CNT_W-1:0];
  localparam [`SHC_CNT_W-1:0] NEXT_LAST = RESUME_NEXT_LAST[`SHC_CNT_W-1:0];

  // ----------------------------------------
  // Settle count for a select code
  // ----------------------------------------
  // Prohibited codes fall back to the longest wait
  function [`SHC_CNT_W-1:0] settleCount;
    input [`SHC_SEL_W-1:0] sel;
    begin
      case (sel)
        `SHC_SEL_2P12: settleCount = CNT_2P12_W;
        `SHC_SEL_2P15: settleCount = CNT_2P15[`SHC_CNT_W-1:0];
        `SHC_SEL_2P17: settleCount = CNT_2P17[`SHC_CNT_W-1:0];
        default: settleCount = CNT_2P17[`SHC_CNT_W-1:0];
      endcase
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [`SHC_SEL_W-1:0] settleSel_q;
  reg [`SHC_CNT_W-1:0] cnt_q;
  reg [`SHC_CNT_W-1:0] cnt_d;
  reg [`SHC_CNT_W-1:0] target_q;
  reg [`SHC_CNT_W-1:0] target_d;
  reg fromReset_q;
  reg fromReset_d;
  reg oscWasOff_q;
  reg oscWasOff_d;
  reg vector_q;
  reg vector_d;
  reg oscSync1_q;
  reg oscSync2_q;
  reg oscEnable_d;
  reg cpuClkEn_d;
  reg resumeVector_d;
  reg resumeNext_d;
  reg resetStart_d;
  reg periphStop;

  // ----------------------------------------
  // Wake decode
  // ----------------------------------------
  // request set and mask clear
  wire [NUM_IRQ-1:0] eligible = irqRequestFlag & ~irqMaskFlag;
  wire maskWake = |eligible;
  wire haltWake = maskWake | nmiReq;

  // ----------------------------------------
  // Address decode and settle compare
  // ----------------------------------------
  // Word index only; byte lanes are not decoded
  wire accessPhase = psel & penable;
  wire hitSelect = (paddr[17:2] == `SHC_SETTLE_SEL_IDX);
  wire hitStat = (paddr[17:2] == `SHC_STAT_IDX);
  wire cntDone = (cnt_q == target_q - CNT_ONE);

  // ----------------------------------------
  // Oscillator running synchroniser
  // ----------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      oscSync1_q <= 1'b0;
      oscSync2_q <= 1'b0;
    end else begin
      oscSync1_q <= oscRunning;
      oscSync2_q <= oscSync1_q;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Answer one cycle into the access phase
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (accessPhase && !pready) begin
      pready <= 1'b1;
      pslverr <= ~(hitSelect | hitStat);
      prdata <= 32'h00000000;
      if (hitSelect) begin
        prdata[`SHC_SEL_W-1:0] <= settleSel_q;
      end else if (hitStat) begin
        prdata[`SHC_STAT_STATE_LSB+2:`SHC_STAT_STATE_LSB] <= state_q;
        prdata[`SHC_STAT_RESET_BIT] <= fromReset_q;
        prdata[`SHC_STAT_OSCOFF_BIT] <= ~oscEnable_q;
        prdata[`SHC_STAT_OSCRDY_BIT] <= oscSync2_q;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // Settle select register
  // ----------------------------------------
  // reset loads code 4
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      settleSel_q <= `SHC_SETTLE_SEL_RST;
    end else if (accessPhase && pready && pwrite && hitSelect) begin
      // Upper write bits dropped, code bits only
      settleSel_q <= pwdata[`SHC_SEL_W-1:0];
    end
  end

  // ----------------------------------------
  // Standby sequencer, next state
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    target_d = target_q;
    fromReset_d = fromReset_q;
    oscWasOff_d = oscWasOff_q;
    vector_d = vector_q;
    oscEnable_d = oscEnable_q;
    cpuClkEn_d = cpuClkEn_q;
    resumeVector_d = 1'b0;
    resumeNext_d = 1'b0;
    resetStart_d = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (stopExec) begin
          target_d = settleCount(settleSel_q);
          cpuClkEn_d = 1'b0;
          cnt_d = {`SHC_CNT_W{1'b0}};
          if (maskWake) begin
            state_d = ST_SETTLE;
            oscWasOff_d = 1'b0;
          end else begin
            state_d = ST_STOP;
            oscEnable_d = 1'b0;
            oscWasOff_d = 1'b1;
          end
        end else if (haltExec) begin
          state_d = ST_HALT;
          cpuClkEn_d = 1'b0;
        end
      end
      ST_HALT: begin
        if (haltWake) begin
          vector_d = nmiReq | irqGlobalAllow;
          state_d = ST_RESUME;
          cnt_d = {`SHC_CNT_W{1'b0}};
          cpuClkEn_d = 1'b1;
        end
      end
      ST_STOP: begin
        if (maskWake) begin
          state_d = ST_OSCUP;
          oscEnable_d = 1'b1;
        end
      end
      ST_OSCUP: begin
        // count waits for a running oscillator
        if (oscSync2_q) begin
          state_d = ST_SETTLE;
          cnt_d = {`SHC_CNT_W{1'b0}};
        end
      end
      ST_SETTLE: begin
        cnt_d = cnt_q + CNT_ONE;
        if (cntDone) begin
          cnt_d = {`SHC_CNT_W{1'b0}};
          oscWasOff_d = 1'b0;
          cpuClkEn_d = 1'b1;
          if (fromReset_q) begin
            // reset runs after the settle wait
            fromReset_d = 1'b0;
            resetStart_d = 1'b1;
            state_d = ST_RUN;
          end else begin
            vector_d = irqGlobalAllow;
            state_d = ST_RESUME;
          end
        end
      end
      ST_RESUME: begin
        cnt_d = cnt_q + CNT_ONE;
        if (vector_q ? (cnt_q == VEC_LAST) : (cnt_q == NEXT_LAST)) begin
          resumeVector_d = vector_q;
          resumeNext_d = ~vector_q;
          cnt_d = {`SHC_CNT_W{1'b0}};
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
        cpuClkEn_d = 1'b1;
        oscEnable_d = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Standby sequencer, state registers
  // ----------------------------------------
  // reset restarts in ST_OSCUP with reset wait
  // reset wait is the 2^15 count
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_OSCUP;
      cnt_q <= {`SHC_CNT_W{1'b0}};
      target_q <= CNT_RESET[`SHC_CNT_W-1:0];
      fromReset_q <= 1'b1;
      oscWasOff_q <= 1'b0;
      vector_q <= 1'b0;
      oscEnable_q <= 1'b1;
      cpuClkEn_q <= 1'b0;
      resumeVector_q <= 1'b0;
      resumeNext_q <= 1'b0;
      resetStart_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      target_q <= target_d;
      fromReset_q <= fromReset_d;
      oscWasOff_q <= oscWasOff_d;
      vector_q <= vector_d;
      oscEnable_q <= oscEnable_d;
      cpuClkEn_q <= cpuClkEn_d;
      resumeVector_q <= resumeVector_d;
      resumeNext_q <= resumeNext_d;
      resetStart_q <= resetStart_d;
    end
  end

  // ----------------------------------------
  // Peripheral clock gating
  // ----------------------------------------
  // timers and watchdog stop with oscillator
  always @* begin
    periphStop = (state_d == ST_STOP) || (state_d == ST_OSCUP && !fromReset_d) ||
      (state_d == ST_SETTLE && oscWasOff_d);
  end

  // ----------------------------------------
  // Peripheral gate registers
  // ----------------------------------------
  // halt keeps peripherals clocked
  // no held state is cleared by standby
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      timerClkEn_q <= 1'b1;
      wdtClkEn_q <= 1'b1;
      serialClkEn_q <= 1'b1;
      lowVoltDetEn_q <= 1'b1;
      wakeDetEnable_q <= 1'b1;
      powerClearEn_q <= 1'b0;
    end else begin
      timerClkEn_q <= ~periphStop;
      wdtClkEn_q <= ~periphStop;
      serialClkEn_q <= ~periphStop | serialExtClkSel;
      lowVoltDetEn_q <= 1'b1;
      wakeDetEnable_q <= 1'b1;
      powerClearEn_q <= ~powerClearIrqMask;
    end
  end

endmodule

/* File: tb/shc_checker.sv */
`timescale 1ns/1ns
`include "shc_consts.vh"

// --------
// Port checker
// --------
module shc_checker #(
  parameter NUM_IRQ = 8
) (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // APB
  input wire psel,
  input wire penable,
  input wire [17:0] paddr,
  input wire pready,
  input wire pslverr,
  // CPU and interrupts
  input wire haltExec,
  input wire stopExec,
  input wire [NUM_IRQ-1:0] irqRequestFlag,
  input wire [NUM_IRQ-1:0] irqMaskFlag,
  input wire irqGlobalAllow,
  input wire nmiReq,
  input wire powerClearIrqMask,
  input wire serialExtClkSel,
  // Gates and resume
  input wire oscEnable_q,
  input wire cpuClkEn_q,
  input wire resumeVector_q,
  input wire resumeNext_q,
  input wire timerClkEn_q,
  input wire wdtClkEn_q,
  input wire serialClkEn_q,
  input wire powerClearEn_q
);
  wire elig = |(irqRequestFlag & ~irqMaskFlag);
  wire unmap = paddr[17:2] != `SHC_SETTLE_SEL_IDX && paddr[17:2] != `SHC_STAT_IDX;
  reg inHalt_q;

  // Halt from command to wake
  always @(posedge mclk or negedge resetn) begin
    if (!resetn)
      inHalt_q <= 1'b0;
    else if (cpuClkEn_q && haltExec && !stopExec)
      inHalt_q <= 1'b1;
    else if (elig || nmiReq)
      inHalt_q <= 1'b0;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_PWR_CLEAR: assert property ($past(resetn) |-> powerClearEn_q == !$past(powerClearIrqMask))
    else $error("poc gate");
  AST_APB_RDY: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready pulse");
  AST_APB_ERR: assert property (pready |-> pslverr == unmap)
    else $error("pslverr");
  AST_HALT_OSC: assert property (inHalt_q |-> !cpuClkEn_q && oscEnable_q && timerClkEn_q
    && wdtClkEn_q && serialClkEn_q)
    else $error("halt gates");
  AST_HALT_NEXT: assert property (inHalt_q && elig && !nmiReq && !irqGlobalAllow
    |=> cpuClkEn_q ##1 resumeNext_q)
    else $error("halt next");
  AST_HALT_VEC: assert property (inHalt_q && (nmiReq || elig && irqGlobalAllow)
    |=> cpuClkEn_q ##9 resumeVector_q)
    else $error("halt vector");
  AST_STOP_GATE: assert property (cpuClkEn_q && stopExec && !elig |=> !oscEnable_q)
    else $error("stop entry");
  AST_STOP_HOLD: assert property (!oscEnable_q && !elig |=> !oscEnable_q)
    else $error("stop left");
  AST_STOP_WAKE: assert property (!oscEnable_q && elig |=> oscEnable_q)
    else $error("stop wake");
  AST_STOP_PERIPH: assert property (!oscEnable_q && $past(!oscEnable_q) |-> !timerClkEn_q
    && !wdtClkEn_q && serialClkEn_q == $past(serialExtClkSel))
    else $error("stop gates");

  cover property (inHalt_q && nmiReq);
  cover property ($rose(oscEnable_q));
  cover property (pready && pslverr);
endmodule

bind shc_standby_ctrl shc_checker #(.NUM_IRQ(NUM_IRQ)) i_shc_checker (
  .mclk, .resetn, .psel, .penable, .paddr, .pready, .pslverr, .haltExec, .stopExec,
  .irqRequestFlag, .irqMaskFlag, .irqGlobalAllow, .nmiReq, .powerClearIrqMask,
  .serialExtClkSel, .oscEnable_q, .cpuClkEn_q, .resumeVector_q, .resumeNext_q,
  .timerClkEn_q, .wdtClkEn_q, .serialClkEn_q, .powerClearEn_q
);

/* File: tb/shc_cpu_model.sv */
`timescale 1ns/1ns

// --------
// CPU core and oscillator model
// --------
module shc_cpu_model #(
  parameter OSC_START = 20
) (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // Bench commands
  input wire doHalt,
  input wire doStop,
  // Controller side
  input wire oscEnable_q,
  input wire cpuClkEn_q,
  output reg haltExec,
  output reg stopExec,
  output reg oscRunning
);
  integer startCnt;

  // Instructions only while the CPU runs
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      haltExec <= 1'b0;
      stopExec <= 1'b0;
    end else begin
      haltExec <= doHalt && cpuClkEn_q;
      stopExec <= doStop && cpuClkEn_q;
    end
  end

  // Oscillator needs a start-up span
  always @(posedge mclk or negedge resetn) begin
    if (!resetn || !oscEnable_q) begin
      startCnt <= 0;
      oscRunning <= 1'b0;
    end else if (startCnt < OSC_START)
      startCnt <= startCnt + 1;
    else
      oscRunning <= 1'b1;
  end
endmodule

/* File: tb/shc_standby_ctrl_tb.sv */
`timescale 1ns/1ns
`include "shc_consts.vh"

module shc_standby_ctrl_tb;
  localparam int N15 = 64;
  localparam int N17 = 128;
  localparam logic [17:0] SEL_A = {`SHC_SETTLE_SEL_IDX, 2'b00};
  localparam logic [17:0] STAT_A = {`SHC_STAT_IDX, 2'b00};
  logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, doHalt = 0, doStop = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, rnd;
  logic [7:0] irqRequestFlag = 0, irqMaskFlag = 8'hff, bit8;
  logic irqGlobalAllow = 0, nmiReq = 0, powerClearIrqMask = 0, serialExtClkSel = 0;
  logic pready, pslverr, e, haltExec, stopExec, oscRunning, oscEnable_q, cpuClkEn_q;
  logic resumeVector_q, resumeNext_q, resetStart_q, timerClkEn_q, wdtClkEn_q;
  logic serialClkEn_q, lowVoltDetEn_q, wakeDetEnable_q, powerClearEn_q;
  logic [2:0] codes [4] = '{3'h0, 3'h2, 3'h4, 3'h7};
  int wt [4] = '{`SHC_CNT_2P12, N15, N17, N17};
  int seed = 32'h54025611, error_cnt = 0, checks_done = 0, k;

  shc_standby_ctrl #(.CNT_2P15(N15), .CNT_2P17(N17), .CNT_RESET(N15)) i_shc_standby_ctrl (
    .mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .haltExec, .stopExec, .irqRequestFlag, .irqMaskFlag, .irqGlobalAllow, .nmiReq,
    .powerClearIrqMask, .serialExtClkSel, .oscRunning, .oscEnable_q, .cpuClkEn_q,
    .resumeVector_q, .resumeNext_q, .resetStart_q, .timerClkEn_q, .wdtClkEn_q,
    .serialClkEn_q, .lowVoltDetEn_q, .wakeDetEnable_q, .powerClearEn_q
  );
  shc_cpu_model i_shc_cpu_model (.mclk, .resetn, .doHalt, .doStop, .oscEnable_q,
    .cpuClkEn_q, .haltExec, .stopExec, .oscRunning);

  // Clock
  initial forever #5 mclk = ~mclk;

  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int c;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    c = 0;
    do begin
      tick(1);
      c++;
    end while (pready !== 1'b1 && c < 50);
    if (c >= 50)
      error_cnt++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask

  task cmd(input logic h);
    doHalt <= h;
    doStop <= !h;
    tick(1);
    doHalt <= 1'b0;
    doStop <= 1'b0;
  endtask

  task settle(input int n);
    int c;
    c = 0;
    while (oscRunning !== 1'b1 && c < 500) begin
      tick(1);
      c++;
    end
    if (c >= 500)
      error_cnt++;
    c = 0;
    while (cpuClkEn_q !== 1'b1 && c < 5000) begin
      tick(1);
      c++;
    end
    check(c >= n - 2 && c <= n + 6, 1);
  endtask

  task resume(input logic vec);
    int c;
    c = 0;
    while (resumeVector_q !== 1'b1 && resumeNext_q !== 1'b1 && c < 20) begin
      tick(1);
      c++;
    end
    check({resumeVector_q, resumeNext_q}, {vec, !vec});
    irqRequestFlag <= 8'h0;
    irqMaskFlag <= 8'hff;
    nmiReq <= 1'b0;
    tick(2);
  endtask

  task doReset;
    int c;
    resetn <= 1'b0;
    tick(12);
    resetn <= 1'b1;
    settle(N15);
    c = 0;
    while (resetStart_q !== 1'b1 && c < 12) begin
      tick(1);
      c++;
    end
    check(resetStart_q, 1);
    apb(1'b0, SEL_A, 32'h0);
    check(r, `SHC_SETTLE_SEL_RST);
  endtask

  task conclude;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial begin
    doReset;
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      rnd = $random(seed);
      apb(1'b1, SEL_A, rnd);
      apb(1'b0, SEL_A, 32'h0);
      check(r, rnd & 32'h7);
    end
    apb(1'b0, 18'h0, 32'h0);
    check({e, r[30:0]}, 32'h80000000);
    $display("test apb done");
    for (k = 0; k < 3; k++) begin
      rnd = $random(seed);
      bit8 = 8'h1 << rnd[5:3];
      irqGlobalAllow <= (k == 1);
      cmd(1'b1);
      irqRequestFlag <= bit8;
      tick(6);
      check(cpuClkEn_q, 0);
      if (k == 2)
        nmiReq <= 1'b1;
      else
        irqMaskFlag <= ~bit8;
      resume(k != 0);
    end
    $display("test halt done");
    codes[3] = 3'h1 | (rnd[2:0] & 3'h6);
    for (k = 0; k < 4; k++) begin
      apb(1'b1, SEL_A, {29'h0, codes[k]});
      rnd = $random(seed);
      bit8 = 8'h1 << rnd[5:3];
      serialExtClkSel <= rnd[0];
      powerClearIrqMask <= rnd[1];
      irqGlobalAllow <= rnd[2];
      cmd(1'b0);
      nmiReq <= 1'b1;
      irqRequestFlag <= bit8;
      tick(10);
      check({oscEnable_q, lowVoltDetEn_q, wakeDetEnable_q}, 3'h3);
      apb(1'b0, STAT_A, 32'h0);
      check(r, 32'h12);
      nmiReq <= 1'b0;
      irqMaskFlag <= rnd[15:8] & ~bit8;
      settle(wt[k]);
      resume(irqGlobalAllow);
    end
    apb(1'b0, SEL_A, 32'h0);
    check(r, {29'h0, codes[3]});
    irqRequestFlag <= bit8;
    irqMaskFlag <= ~bit8;
    irqGlobalAllow <= 1'b0;
    cmd(1'b0);
    tick(2);
    check(oscEnable_q, 1);
    settle(N17);
    resume(1'b0);
    cmd(1'b0);
    tick(3);
    check(oscEnable_q, 0);
    doReset;
    $display("test stop done");
    conclude;
  end

  // Watchdog
  initial begin
    tick(30000);
    error_cnt++;
    conclude;
  end
endmodule
